// *** cie_alu.sv ***
// combinational arithmetic unit for the instruction subset
`default_nettype none
module cie_alu (
  input  wire cie_pkg::cie_op_t op_i,
  input  wire logic [7:0]       acc_i,
  input  wire logic [7:0]       opnd_i,
  output logic      [7:0]       res_o,
  output logic                  borrow_o,
  output logic                  half_o
);
  logic [8:0] diff;
  logic [4:0] hdiff;
  always_comb begin
    diff     = {1'b0, opnd_i} + {1'b0, ~acc_i} + 9'h001;
    hdiff    = {1'b0, opnd_i[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
    borrow_o = diff[8];
    half_o   = hdiff[4];
    case (op_i)
      cie_pkg::CIE_OP_SUB_LIT,
      cie_pkg::CIE_OP_SUB_FILE: res_o = diff[7:0];
      cie_pkg::CIE_OP_XOR_LIT,
      cie_pkg::CIE_OP_XOR_FILE: res_o = acc_i ^ opnd_i;
      cie_pkg::CIE_OP_SWAP:     res_o = {opnd_i[3:0], opnd_i[7:4]}; // RULE_08
      default:                  res_o = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// *** cie_exec.sv ***
// execution of sleep, subtract, xor and nibble swap instructions
`default_nettype none
// Contract
// RULE_01 - sleep clears sleep flag, sets expiry flag
// RULE_02 - sleep clears watchdog counter and prescaler
// RULE_03 - sleep halts execution until wake-up
// RULE_04 - literal minus accumulator, borrow, half, null flags
// RULE_05 - accumulator xor literal, only null flag
// RULE_06 - file minus accumulator, borrow, half, null flags
// RULE_07 - subtract result to acc or file
// RULE_08 - nibble swap exchanges file nibbles
// RULE_09 - swap steered by target, no flags
// RULE_10 - acc xor file, steered, null only
// RULE_11 - null flag set on zero result
module cie_exec (
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  input  wire logic                 instr_valid_i,
  input  wire cie_pkg::cie_instr_t  instr_i,
  input  wire logic [7:0]           file_rdata_i,
  input  wire logic                 wake_i,
  output logic      [6:0]           file_raddr_o,
  output var  cie_pkg::cie_fwrite_t file_wr_o,
  output logic      [7:0]           acc_o,
  output var  cie_pkg::cie_status_t status_o,
  output logic                      watchdog_clear_o,
  output logic                      osc_halt_o,
  output logic                      busy_sleep_o
);
  // decoded strobes of the instruction taken this cycle
  logic                 exec;
  logic                 go_sleep;
  logic                 upd_arith;
  logic                 upd_null;
  logic                 acc_load;
  logic                 steered;
  logic                 to_file;

  // arithmetic unit
  logic [7:0]           opnd;
  logic [7:0]           res;
  logic                 borrow;
  logic                 half;

  // run state and halt flag
  cie_pkg::cie_state_t  state_reg, state_next;
  logic                 halt_reg, halt_next;

  // accumulator, status, file write port, watchdog clear
  logic [7:0]           acc_reg, acc_next;
  cie_pkg::cie_status_t st_reg, st_next;
  cie_pkg::cie_fwrite_t fw_reg, fw_next;
  logic                 wdog_reg, wdog_next;

  assign opnd = (instr_i.op == cie_pkg::CIE_OP_SUB_LIT || instr_i.op == cie_pkg::CIE_OP_XOR_LIT)
                ? instr_i.imm : file_rdata_i;

  cie_alu u_alu (
    .op_i     (instr_i.op),
    .acc_i    (acc_reg),
    .opnd_i   (opnd),
    .res_o    (res),
    .borrow_o (borrow),
    .half_o   (half)
  );

  // instructions are ignored while the core sleeps
  always_comb begin
    exec      = instr_valid_i && (state_reg == cie_pkg::CIE_ST_RUN);
    go_sleep  = 1'b0;
    upd_arith = 1'b0;
    upd_null  = 1'b0;
    acc_load  = 1'b0;
    steered   = 1'b0;
    if (exec) begin
      case (instr_i.op)
        cie_pkg::CIE_OP_SLEEP: begin
          go_sleep = 1'b1; // RULE_01 RULE_02 RULE_03
        end
        cie_pkg::CIE_OP_SUB_LIT: begin
          acc_load  = 1'b1; // RULE_04
          upd_arith = 1'b1; // RULE_04
          upd_null  = 1'b1; // RULE_11
        end
        cie_pkg::CIE_OP_XOR_LIT: begin
          acc_load = 1'b1; // RULE_05
          upd_null = 1'b1; // RULE_05 RULE_11
        end
        cie_pkg::CIE_OP_SUB_FILE: begin
          steered   = 1'b1; // RULE_07
          upd_arith = 1'b1; // RULE_06
          upd_null  = 1'b1; // RULE_11
        end
        cie_pkg::CIE_OP_XOR_FILE: begin
          steered  = 1'b1; // RULE_10
          upd_null = 1'b1; // RULE_10 RULE_11
        end
        cie_pkg::CIE_OP_SWAP: begin
          steered = 1'b1; // RULE_09
        end
        default: begin
        end
      endcase
    end
    to_file = steered && (instr_i.target_select == cie_pkg::DEST_FILE); // RULE_07 RULE_09 RULE_10
  end

  // run state: sleep entry and wake-up
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cie_pkg::CIE_ST_RUN: begin
        if (go_sleep) begin
          state_next = cie_pkg::CIE_ST_SLEEP; // RULE_03
        end
      end
      cie_pkg::CIE_ST_SLEEP: begin
        if (wake_i) begin
          state_next = cie_pkg::CIE_ST_RUN; // RULE_03
        end
      end
      default: state_next = cie_pkg::CIE_ST_RUN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= cie_pkg::CIE_ST_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // halt flag, registered copy of the sleep state
  always_comb begin
    halt_next = (state_next == cie_pkg::CIE_ST_SLEEP); // RULE_03
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      halt_reg <= 1'b0;
    end else begin
      halt_reg <= halt_next;
    end
  end

  // accumulator
  always_comb begin
    acc_next = acc_reg;
    if (acc_load || (steered && !to_file)) begin
      acc_next = res; // RULE_04 RULE_05 RULE_07 RULE_09 RULE_10
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      acc_reg <= cie_pkg::ACC_RST;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // status flags
  always_comb begin
    st_next = st_reg;
    if (go_sleep) begin
      st_next.sleep_entered_flag = 1'b0; // RULE_01
      st_next.expiry_flag        = 1'b1; // RULE_01
    end
    if (upd_arith) begin
      st_next.borrow_out_bit  = borrow; // RULE_04 RULE_06
      st_next.half_borrow_bit = half; // RULE_04 RULE_06
    end
    if (upd_null) begin
      st_next.result_null_flag = (res == 8'h00); // RULE_11
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      st_reg <= cie_pkg::STATUS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // file write port, one-cycle strobe
  always_comb begin
    fw_next = '0;
    if (to_file) begin
      fw_next = '{we: 1'b1, addr: instr_i.faddr, data: res}; // RULE_07 RULE_09 RULE_10
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      fw_reg <= '0;
    end else begin
      fw_reg <= fw_next;
    end
  end

  // watchdog clear, one-cycle pulse
  always_comb begin
    wdog_next = go_sleep; // RULE_02
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wdog_reg <= 1'b0;
    end else begin
      wdog_reg <= wdog_next;
    end
  end

  // read address is the decoder's field; file array is outside
  always_comb begin
    file_raddr_o = instr_i.faddr;
  end

  assign file_wr_o        = fw_reg;
  assign acc_o            = acc_reg;
  assign status_o         = st_reg;
  assign watchdog_clear_o = wdog_reg; // RULE_02
  assign osc_halt_o       = halt_reg; // RULE_03
  assign busy_sleep_o     = halt_reg;
endmodule
`default_nettype wire

// *** cie_exec_assertions.sv ***
// checker for the execution subset
`default_nettype none
module cie_exec_assertions (
  input wire logic                 clk_i,
  input wire logic                 srst_i,
  input wire logic                 instr_valid_i,
  input wire cie_pkg::cie_instr_t  instr_i,
  input wire logic [7:0]           file_rdata_i,
  input wire logic                 wake_i,
  input wire cie_pkg::cie_fwrite_t file_wr_o,
  input wire logic [7:0]           acc_o,
  input wire cie_pkg::cie_status_t status_o,
  input wire logic                 watchdog_clear_o,
  input wire logic                 osc_halt_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  logic go;
  logic wr;
  assign go = instr_valid_i && !osc_halt_o;
  assign wr = go && instr_i.op[2] && instr_i.target_select;
  sequence s_sleep;
    go && instr_i.op == cie_pkg::CIE_OP_SLEEP;
  endsequence
  sequence s_pulse;
    watchdog_clear_o ##1 !watchdog_clear_o;
  endsequence
  a_sleep_flags: assert property (s_sleep |=> osc_halt_o && status_o[1:0] == 2'h1)
    else $error("sleep flags");
  a_watchdog_pulse: assert property (s_sleep |=> s_pulse)
    else $error("watchdog pulse");
  a_halt_hold: assert property (osc_halt_o |=> $stable(acc_o) && !file_wr_o.we && osc_halt_o != $past(wake_i))
    else $error("halt");
  a_file_write: assert property (wr |=> file_wr_o.we && file_wr_o.addr == $past(instr_i.faddr))
    else $error("file write");
  a_acc_target: assert property (go && !wr |=> !file_wr_o.we)
    else $error("acc target");
  a_swap_flags: assert property (go && instr_i.op == cie_pkg::CIE_OP_SWAP |=> $stable(status_o))
    else $error("swap flags");
  a_xor_flags: assert property (go && instr_i.op[0] && instr_i.op[2:1] != 2'h0 |=> $stable(status_o[4:3]))
    else $error("xor flags");
  a_null_flag: assert property (go && instr_i.op[2:1] == 2'h1 |=> status_o[2] == (acc_o == 8'h00))
    else $error("null flag");
  a_swap_data: assert property (wr && instr_i.op == cie_pkg::CIE_OP_SWAP |=>
    file_wr_o.data == {$past(file_rdata_i[3:0]), $past(file_rdata_i[7:4])})
    else $error("swap data");
  a_sub_borrow: assert property (go && instr_i.op == cie_pkg::CIE_OP_SUB_FILE |=>
    status_o[4] == ($past(file_rdata_i) >= $past(acc_o)))
    else $error("subtract borrow");
endmodule
bind cie_exec cie_exec_assertions u_chk (.clk_i, .srst_i, .instr_valid_i, .instr_i, .file_rdata_i, .wake_i,
  .file_wr_o, .acc_o, .status_o, .watchdog_clear_o, .osc_halt_o);
`default_nettype wire

// *** cie_exec_tb.sv ***
// bench for the execution subset
`default_nettype none
module cie_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i = 1'b0;
  logic                 srst_i = 1'b1;
  logic                 instr_valid_i = 1'b0;
  cie_pkg::cie_instr_t  instr_i = '0;
  logic [7:0]           file_rdata_i = 8'h00;
  logic                 wake_i = 1'b0;
  cie_pkg::cie_fwrite_t file_wr_o;
  logic [7:0]           acc_o;
  cie_pkg::cie_status_t status_o;
  logic                 watchdog_clear_o;
  logic                 osc_halt_o;
  logic                 busy_sleep_o;
  logic [6:0]           file_raddr_o;
  logic [7:0]           m;
  int                   mismatches = 0;
  int                   comparisons = 0;
  always #2 clk_i = ~clk_i;
  cie_exec DUT (.clk_i, .srst_i, .instr_valid_i, .instr_i, .file_rdata_i, .wake_i, .file_raddr_o,
    .file_wr_o, .acc_o, .status_o, .watchdog_clear_o, .osc_halt_o, .busy_sleep_o);
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic run(cie_pkg::cie_op_t op, logic [7:0] k, logic [7:0] f, logic t);
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_i <= '{op, k, 7'h05, t};
    file_rdata_i <= f;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  task automatic rst();
    @(posedge clk_i);
    srst_i <= 1'b1;
    @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    m = 8'h00;
    chk("reset", {acc_o, status_o, file_wr_o.we, watchdog_clear_o, osc_halt_o}, 16'h0018);
  endtask
  task automatic t_alu();
    logic [7:0] ks [4] = '{8'h00, 8'h01, 8'h10, 8'hff};
    logic [7:0] k;
    foreach (ks[i]) begin
      run(cie_pkg::CIE_OP_XOR_LIT, ks[i], 8'h00, 1'b0);
      m = m ^ ks[i];
      chk("xor", {acc_o, status_o[2]}, {m, m == 8'h00});
      k = ks[3 - i];
      run(cie_pkg::CIE_OP_SUB_LIT, k, 8'h00, 1'b0);
      chk("sub", {acc_o, status_o[4:2]}, {k - m, k >= m, k[3:0] >= m[3:0], k == m});
      m = k - m;
    end
    $display("alu done");
  endtask
  task automatic t_file();
    cie_pkg::cie_op_t ops [3] = '{cie_pkg::CIE_OP_SUB_FILE, cie_pkg::CIE_OP_XOR_FILE, cie_pkg::CIE_OP_SWAP};
    logic [7:0] r;
    logic [2:0] fl;
    run(cie_pkg::CIE_OP_XOR_LIT, 8'h01, 8'h00, 1'b0);
    m = 8'h01;
    fl = 3'h0;
    for (int t = 1; t >= 0; t--) begin
      foreach (ops[i]) begin
        r = (i == 0) ? 8'h10 - m : (i == 1) ? m ^ 8'h10 : 8'h01;
        if (i == 0) fl = {8'h10 >= m, 4'h0 >= m[3:0], r == 8'h00};
        if (i == 1) fl[0] = (r == 8'h00);
        run(ops[i], 8'h00, 8'h10, t[0]);
        if (t == 0) m = r;
        else chk("fwr", file_wr_o, {1'b1, 7'h05, r});
        chk("acc", {acc_o, file_wr_o.we}, {m, t[0]});
        chk("flags", status_o[4:2], fl);
        chk("raddr", file_raddr_o, 7'h05);
      end
    end
    $display("file done");
  endtask
  task automatic t_sleep();
    run(cie_pkg::CIE_OP_SLEEP, 8'h00, 8'h00, 1'b0);
    chk("sleep", {watchdog_clear_o, osc_halt_o, busy_sleep_o, status_o[1:0]}, 5'h1d);
    run(cie_pkg::CIE_OP_XOR_LIT, 8'hff, 8'h00, 1'b0);
    chk("asleep", {watchdog_clear_o, osc_halt_o, acc_o}, {2'h1, m});
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    run(cie_pkg::CIE_OP_XOR_LIT, 8'h0f, 8'h00, 1'b0);
    chk("woken", {osc_halt_o, acc_o}, {1'b0, m ^ 8'h0f});
    $display("sleep done");
  endtask
  initial begin
    rst();
    t_alu();
    rst();
    t_file();
    t_sleep();
    summarize();
  end
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire

// *** cie_pkg.sv ***
// shared types and constants for the instruction execution subset
`default_nettype none
package cie_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 7;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic [7:0]  WATCHDOG_CLEAR = 8'h00;
  localparam logic        DEST_ACC   = 1'b0;
  localparam logic        DEST_FILE  = 1'b1;

  typedef enum logic [2:0] {
    CIE_OP_NONE     = 3'h0,
    CIE_OP_SLEEP    = 3'h1,
    CIE_OP_SUB_LIT  = 3'h2,
    CIE_OP_XOR_LIT  = 3'h3,
    CIE_OP_SUB_FILE = 3'h4,
    CIE_OP_XOR_FILE = 3'h5,
    CIE_OP_SWAP     = 3'h6
  } cie_op_t;

  typedef enum logic [1:0] {
    CIE_ST_RUN   = 2'b00,
    CIE_ST_SLEEP = 2'b01
  } cie_state_t;

  typedef struct packed {
    cie_op_t          op;
    logic [7:0]       imm;
    logic [6:0]       faddr;
    logic             target_select;
  } cie_instr_t;

  typedef struct packed {
    logic borrow_out_bit;
    logic half_borrow_bit;
    logic result_null_flag;
    logic sleep_entered_flag;
    logic expiry_flag;
  } cie_status_t;

  localparam cie_status_t STATUS_RST = '{sleep_entered_flag: 1'b1, expiry_flag: 1'b1, default: 1'b0};

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } cie_fwrite_t;
endpackage
`default_nettype wire
